// ===== dnds_top.sv
// The APB slave port and the register offsets were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "dnds_regs.svh"
module dnds_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic seq_active,
  input wire logic warmup_start,
  input wire logic preamble_search,
  input wire logic rx_busy,
  input wire logic rx_done,
  input wire logic rx_fcs_ok,
  input wire dnds_pkg::dnds_rx_t rx_frame,
  input wire logic src_check,
  input wire logic [15:0] src_checksum,
  output logic current_network,
  output logic [7:0] sel_channel,
  output logic shared_channel,
  output logic preamble_blind,
  output logic net_switch,
  output logic data_ind,
  output logic rx_drop,
  output logic src_hit,
  output logic src_done,
  output logic rx_matched_net0_flag,
  output logic rx_matched_net1_flag
);
  dnds_pkg::dnds_state_t s_r;
  dnds_pkg::dnds_state_t s_nxt;

  function automatic logic addr_ok(
    input dnds_pkg::dnds_rx_t f,
    input logic [15:0] id,
    input logic [15:0] sh,
    input logic [63:0] lg,
    input logic coord
  );
    logic id_ok;
    id_ok = (f.dst_net_id == id) || (f.dst_net_id == `DNDS_BCAST);
    case (f.dst_mode)
      2'h2: addr_ok = id_ok && ((f.dst_short == sh) || (f.dst_short == `DNDS_BCAST));
      2'h3: addr_ok = id_ok && (f.dst_long == lg);
      // No destination: only a coordinator accepts it
      default: addr_ok = coord;
    endcase
  endfunction

  function automatic logic table_search(
    input logic [15:0][15:0] tbl,
    input logic [3:0] lvl,
    input logic net,
    input logic [15:0] cs
  );
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < 16; i++) begin
      if (tbl[i] == cs && (net ? (4'(i) >= lvl) : (4'(i) < lvl))) begin // RL18 RL19
        hit = 1'b1;
      end
    end
    table_search = hit;
  endfunction

  logic acc;
  logic wr;
  logic rd;
  logic mapped;
  logic [31:0] rdata;
  logic tbl_sel;
  logic [3:0] tbl_idx;
  logic dwell_wr;
  logic counting;
  logic expired;
  logic do_switch;
  logic m0;
  logic m1;
  logic pkt_ok;

  assign acc = psel && penable && !s_r.rsp.pready;
  assign wr = psel && penable && s_r.rsp.pready && pwrite;
  assign rd = psel && penable && s_r.rsp.pready && !pwrite;
  assign tbl_sel = (paddr[7:6] == 2'h2) && (paddr[1:0] == 2'h0);
  assign tbl_idx = paddr[5:2];

  always_comb begin
    mapped = 1'b1;
    rdata = 32'h0000_0000;
    if (tbl_sel) begin
      rdata = {16'h0000, s_r.table_q[tbl_idx]};
    end else begin
      case (paddr)
        `DNDS_CTRL_OFS: rdata = {28'h000_0000, s_r.coord, s_r.auto_switch_enable,
                                 s_r.active_network};
        `DNDS_DWELL_OFS: rdata = {16'h0000, s_r.dwell_interval};
        `DNDS_LEFT_OFS: rdata = {16'h0000, s_r.dwell_time_left}; // RL8
        `DNDS_STAT_OFS: rdata = {26'h000_0000, s_r.preamble_blind, s_r.pend,
                                 s_r.shared_channel, s_r.rx_matched_net1_flag,
                                 s_r.rx_matched_net0_flag, s_r.current_network}; // RL7
        `DNDS_SPLIT_OFS: rdata = {28'h000_0000, s_r.split};
        `DNDS_CH0_OFS: rdata = {24'h00_0000, s_r.channel[0]};
        `DNDS_CH1_OFS: rdata = {24'h00_0000, s_r.channel[1]};
        `DNDS_SYN_INT_OFS: rdata = {24'h00_0000, s_r.net1_synth_integer};
        `DNDS_SYN_FRAC_OFS: rdata = {16'h0000, s_r.net1_synth_fraction};
        `DNDS_ID0_OFS: rdata = {16'h0000, s_r.net_id[0]};
        `DNDS_ID1_OFS: rdata = {16'h0000, s_r.net_id[1]};
        `DNDS_SHORT0_OFS: rdata = {16'h0000, s_r.short_addr[0]};
        `DNDS_SHORT1_OFS: rdata = {16'h0000, s_r.short_addr[1]};
        `DNDS_LONG0_LO_OFS: rdata = s_r.long_addr[0][31:0];
        `DNDS_LONG0_HI_OFS: rdata = s_r.long_addr[0][63:32];
        `DNDS_LONG1_LO_OFS: rdata = s_r.long_addr[1][31:0];
        `DNDS_LONG1_HI_OFS: rdata = s_r.long_addr[1][63:32];
        default: mapped = 1'b0;
      endcase
    end
  end

  always_comb begin
    s_nxt = s_r;
    // Two-cycle access: first access cycle prepares the registered answer
    s_nxt.rsp.pready = acc;
    s_nxt.rsp.pslverr = acc && !mapped;
    s_nxt.rsp.prdata = acc ? rdata : 32'h0000_0000;
    dwell_wr = 1'b0;
    if (wr && tbl_sel) begin
      s_nxt.table_q[tbl_idx] = pwdata[15:0]; // RL17 RL21
    end else if (wr) begin
      case (paddr)
        `DNDS_CTRL_OFS: begin
          s_nxt.active_network = pwdata[`DNDS_CTRL_ACTIVE_BIT];
          s_nxt.auto_switch_enable = pwdata[`DNDS_CTRL_AUTO_BIT];
          s_nxt.coord = pwdata[`DNDS_CTRL_COORD1_BIT:`DNDS_CTRL_COORD0_BIT];
        end
        `DNDS_DWELL_OFS: begin
          s_nxt.dwell_interval = pwdata[15:0];
          dwell_wr = 1'b1;
        end
        `DNDS_SPLIT_OFS: s_nxt.split = pwdata[3:0]; // RL19
        `DNDS_CH0_OFS: s_nxt.channel[0] = pwdata[7:0];
        `DNDS_CH1_OFS: s_nxt.channel[1] = pwdata[7:0];
        // Plain storage, scratch when only one network is used
        `DNDS_SYN_INT_OFS: s_nxt.net1_synth_integer = pwdata[7:0]; // RL16
        `DNDS_SYN_FRAC_OFS: s_nxt.net1_synth_fraction = pwdata[15:0]; // RL16
        `DNDS_ID0_OFS: s_nxt.net_id[0] = pwdata[15:0];
        `DNDS_ID1_OFS: s_nxt.net_id[1] = pwdata[15:0];
        `DNDS_SHORT0_OFS: s_nxt.short_addr[0] = pwdata[15:0];
        `DNDS_SHORT1_OFS: s_nxt.short_addr[1] = pwdata[15:0];
        `DNDS_LONG0_LO_OFS: s_nxt.long_addr[0][31:0] = pwdata;
        `DNDS_LONG0_HI_OFS: s_nxt.long_addr[0][63:32] = pwdata;
        `DNDS_LONG1_LO_OFS: s_nxt.long_addr[1][31:0] = pwdata;
        `DNDS_LONG1_HI_OFS: s_nxt.long_addr[1][63:32] = pwdata;
        default: ;
      endcase
    end

    s_nxt.shared_channel = (s_r.channel[0] == s_r.channel[1]); // RL13

    // Dwell countdown in microsecond ticks
    counting = s_r.auto_switch_enable && s_r.timer_run && (s_r.dwell_time_left != 16'h0000);
    if (counting) begin // RL5
      if (s_r.tick == 6'(`DNDS_TICK_CYC - 1)) begin
        s_nxt.tick = 6'h00;
        s_nxt.dwell_time_left = s_r.dwell_time_left - 16'h0001;
      end else begin
        s_nxt.tick = s_r.tick + 6'h01;
      end
    end
    if (warmup_start) begin
      s_nxt.timer_run = 1'b1; // RL4
    end
    expired = s_r.auto_switch_enable && s_r.timer_run && (s_r.dwell_time_left == 16'h0000);
    if (expired) begin
      s_nxt.pend = 1'b1;
    end

    // Filter against the serviced net, or both when channels coincide
    m0 = addr_ok(rx_frame, s_r.net_id[0], s_r.short_addr[0], s_r.long_addr[0], s_r.coord[0])
         && (s_r.shared_channel || !s_r.current_network); // RL12 RL13
    m1 = addr_ok(rx_frame, s_r.net_id[1], s_r.short_addr[1], s_r.long_addr[1], s_r.coord[1])
         && (s_r.shared_channel || s_r.current_network); // RL12 RL13
    pkt_ok = rx_fcs_ok && (m0 || m1);
    s_nxt.data_ind = rx_done && pkt_ok;
    s_nxt.rx_drop = rx_done && !pkt_ok;
    if (rx_done && pkt_ok) begin
      s_nxt.rx_matched_net0_flag = m0; // RL14
      s_nxt.rx_matched_net1_flag = m1; // RL14
    end

    // Pending expiry waits out a packet or any non-search state of an active sequence
    do_switch = s_r.auto_switch_enable &&
                ((rx_done && !pkt_ok) || // RL25
                 ((s_r.pend || expired) &&
                  ((preamble_search && !rx_busy) || !seq_active))); // RL23 RL24
    if (do_switch) begin
      s_nxt.current_network = !s_r.current_network; // RL23
      s_nxt.dwell_time_left = s_r.dwell_interval; // RL27
      s_nxt.tick = 6'h00;
      s_nxt.pend = 1'b0;
      s_nxt.blind = 12'(`DNDS_BLIND_CYC); // RL11
    end else if (s_r.blind != 12'h000) begin
      s_nxt.blind = s_r.blind - 12'h001;
    end
    s_nxt.preamble_blind = (s_nxt.blind != 12'h000); // RL11

    // A dwell write overrides any switch reload in the same cycle
    if (dwell_wr) begin
      s_nxt.dwell_time_left = pwdata[15:0]; // RL1 RL2 RL6
      s_nxt.tick = 6'h00;
      s_nxt.pend = 1'b0;
      s_nxt.current_network = s_r.active_network; // RL1
      s_nxt.timer_run = seq_active; // RL3 RL4
    end
    if (!s_nxt.auto_switch_enable) begin
      s_nxt.current_network = s_nxt.active_network; // RL26
    end
    // A switch overridden by a dwell write or auto off is reported only if the serviced net still changes
    s_nxt.net_switch = do_switch && (s_nxt.current_network != s_r.current_network);

    s_nxt.sel_channel = s_nxt.channel[s_nxt.current_network]; // RL12
    s_nxt.src_done = src_check;
    if (src_check) begin
      s_nxt.src_hit = table_search(s_r.table_q, s_r.split, s_r.current_network,
                                   src_checksum); // RL18
    end
  end

  // No sequence start or abort leaves this block
  always_ff @(posedge pclk or negedge presetn) begin // RL9
    if (!presetn) begin
      s_r <= '0;
      s_r.split <= `DNDS_SPLIT_RST; // RL20
      s_r.net1_synth_integer <= `DNDS_SYN_INT_RST;
      s_r.net1_synth_fraction <= `DNDS_SYN_FRAC_RST;
      s_r.shared_channel <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prdata = s_r.rsp.prdata; // RL22
  assign pready = s_r.rsp.pready;
  assign pslverr = s_r.rsp.pslverr;
  assign current_network = s_r.current_network;
  assign sel_channel = s_r.sel_channel;
  assign shared_channel = s_r.shared_channel;
  assign preamble_blind = s_r.preamble_blind;
  assign net_switch = s_r.net_switch;
  assign data_ind = s_r.data_ind;
  assign rx_drop = s_r.rx_drop;
  assign src_hit = s_r.src_hit;
  assign src_done = s_r.src_done;
  assign rx_matched_net0_flag = s_r.rx_matched_net0_flag;
  assign rx_matched_net1_flag = s_r.rx_matched_net1_flag;
endmodule
`default_nettype wire

// ===== dnds_regs.svh
// Contract
// RL1 - Dwell interval write reloads the timer and latches the selected network as start.
// RL2 - Any dwell interval write reinitialises the timer, whatever is in progress.
// RL3 - Write during a running automatic sequence starts the countdown at once.
// RL4 - Write with no sequence holds the timer until the next sequence warm-up.
// RL5 - Timer counts only with automatic switching enabled, otherwise it freezes.
// RL6 - Dwell write loads the timer even with automatic switching disabled.
// RL7 - A readable bit shows which network hardware currently services.
// RL8 - A readable register returns the time left in the current dwell.
// RL9 - Hardware never starts or aborts sequences on its own.
// RL10 - Software may use the start and abort timers to launch or end sequences.
// RL11 - A network switch includes a blind channel change of about 68 us.
// RL12 - After a switch, search on the new channel with its address set.
// RL13 - Equal channels are detected and both address sets filter at once.
// RL14 - On data indication set a received flag per matching network.
// RL15 - In shared-channel use software ignores the serviced-network bit.
// RL16 - Single network: selected bit zero, second-network registers become scratch storage.
// RL17 - Checksum table entries are 16 bits, lower part first network.
// RL18 - Source search covers only the section of the receiving network.
// RL19 - A 4-bit split level gives the first second-network table index.
// RL20 - Split level resets to 12; single network software keeps 12 or more.
// RL21 - Software stores each checksum in the section of its network.
// RL22 - Every writable register reads back exactly what was last written.
// RL23 - Dwell expiry without packet detection switches network, channel and filter.
// RL24 - Expiry during a packet reception postpones the switch until it ends.
// RL25 - A packet failing frame check or filter toggles the network.
// RL26 - With automatic switching off, serviced network follows the selected bit.
// RL27 - Each performed switch reloads the timer with the programmed interval.
`ifndef DNDS_REGS_SVH
`define DNDS_REGS_SVH
`define DNDS_CTRL_OFS 8'h00
`define DNDS_DWELL_OFS 8'h04
`define DNDS_LEFT_OFS 8'h08
`define DNDS_STAT_OFS 8'h0C
`define DNDS_SPLIT_OFS 8'h10
`define DNDS_CH0_OFS 8'h14
`define DNDS_CH1_OFS 8'h18
`define DNDS_SYN_INT_OFS 8'h1C
`define DNDS_SYN_FRAC_OFS 8'h20
`define DNDS_ID0_OFS 8'h24
`define DNDS_ID1_OFS 8'h28
`define DNDS_SHORT0_OFS 8'h2C
`define DNDS_SHORT1_OFS 8'h30
`define DNDS_LONG0_LO_OFS 8'h34
`define DNDS_LONG0_HI_OFS 8'h38
`define DNDS_LONG1_LO_OFS 8'h3C
`define DNDS_LONG1_HI_OFS 8'h40
`define DNDS_TABLE_OFS 8'h80
`define DNDS_CTRL_ACTIVE_BIT 0
`define DNDS_CTRL_AUTO_BIT 1
`define DNDS_CTRL_COORD0_BIT 2
`define DNDS_CTRL_COORD1_BIT 3
`define DNDS_SPLIT_RST 4'hC
`define DNDS_SYN_INT_RST 8'h00
`define DNDS_SYN_FRAC_RST 16'h0000
`define DNDS_CLK_NS 20
`define DNDS_TICK_NS 1000
`define DNDS_TICK_CYC ((`DNDS_TICK_NS + `DNDS_CLK_NS - 1) / `DNDS_CLK_NS)
`define DNDS_BLIND_NS 68000
`define DNDS_BLIND_CYC (`DNDS_BLIND_NS / `DNDS_CLK_NS)
`define DNDS_BCAST 16'hFFFF
`endif

// ===== dnds_pkg.sv
package dnds_pkg;
  typedef struct packed {
    logic [1:0] dst_mode;
    logic [15:0] dst_net_id;
    logic [15:0] dst_short;
    logic [63:0] dst_long;
  } dnds_rx_t;
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } dnds_apb_rsp_t;
  typedef struct packed {
    logic active_network;
    logic auto_switch_enable;
    logic [1:0] coord;
    logic [15:0] dwell_interval;
    logic [15:0] dwell_time_left;
    logic [5:0] tick;
    logic timer_run;
    logic pend;
    logic [11:0] blind;
    logic [3:0] split;
    logic [1:0][7:0] channel;
    logic [7:0] net1_synth_integer;
    logic [15:0] net1_synth_fraction;
    logic [1:0][15:0] net_id;
    logic [1:0][15:0] short_addr;
    logic [1:0][63:0] long_addr;
    logic [15:0][15:0] table_q;
    logic current_network;
    logic rx_matched_net0_flag;
    logic rx_matched_net1_flag;
    logic shared_channel;
    logic preamble_blind;
    logic net_switch;
    logic data_ind;
    logic rx_drop;
    logic src_hit;
    logic src_done;
    logic [7:0] sel_channel;
    dnds_apb_rsp_t rsp;
  } dnds_state_t;
endpackage

// ===== dnds_properties.sv
`timescale 1ns/1ns
`default_nettype none
`include "dnds_regs.svh"
module dnds_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic src_check,
  input wire logic current_network,
  input wire logic shared_channel,
  input wire logic preamble_blind,
  input wire logic net_switch,
  input wire logic data_ind,
  input wire logic rx_drop,
  input wire logic src_hit,
  input wire logic src_done,
  input wire logic rx_matched_net0_flag,
  input wire logic rx_matched_net1_flag
);
  // Shadow of control bits, the real register is not visible here
  logic [1:0] ctl_r;
  logic [11:0] blk_r;
  default clocking dcb @(posedge pclk); endclocking
  default disable iff (!presetn);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_r <= 2'h0;
      blk_r <= 12'h000;
    end else begin
      if (psel && penable && pready && pwrite && !pslverr && paddr == 8'h00) begin
        ctl_r <= pwdata[1:0];
      end
      blk_r <= preamble_blind ? blk_r + 12'h001 : 12'h000;
    end
  end
  a_ready_wait: assert property (psel && penable && !pready |=> pready)
    else $error("pready late");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held");
  a_err_zero: assert property (pready && pslverr |-> prdata == 32'h0)
    else $error("error read not zero");
  // Two stable cycles so a control write in flight is not judged early
  a_follow_sel: assert property (!ctl_r[1] && $stable(ctl_r) ##1 $stable(ctl_r)
    |-> current_network == ctl_r[0])
    else $error("serviced net not following select");
  a_auto_gate: assert property (!ctl_r[1] && $stable(ctl_r) |-> !net_switch)
    else $error("switch with auto off");
  a_switch_flip: assert property (net_switch |-> current_network != $past(current_network))
    else $error("switch without toggle");
  a_switch_blind: assert property (net_switch |-> preamble_blind)
    else $error("no blind at switch");
  a_blind_len: assert property ($fell(preamble_blind) |-> blk_r == `DNDS_BLIND_CYC)
    else $error("blind length wrong");
  a_src_lat: assert property (src_check |=> src_done)
    else $error("source check not done");
  a_ind_flags: assert property (data_ind |-> rx_matched_net0_flag || rx_matched_net1_flag)
    else $error("data without flag");
  a_ind_excl: assert property (!(data_ind && rx_drop))
    else $error("accept and drop together");
  a_single_net: assert property (data_ind && !shared_channel
    |-> rx_matched_net0_flag != rx_matched_net1_flag)
    else $error("both flags off shared channel");
  c_switch: cover property (net_switch);
  c_both: cover property (data_ind && rx_matched_net0_flag && rx_matched_net1_flag);
  c_hit: cover property (src_done ##1 src_hit);
endmodule
`default_nettype wire

// ===== testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q, d;
  logic pready, pslverr, e, current_network, shared_channel, preamble_blind, net_switch;
  logic data_ind, rx_drop, src_hit, src_done, rx_matched_net0_flag, rx_matched_net1_flag;
  logic seq_active = 1'h0, warmup_start = 1'h0, preamble_search = 1'h0, rx_busy = 1'h0;
  logic rx_done = 1'h0, rx_fcs_ok = 1'h0, src_check = 1'h0;
  logic [15:0] src_checksum = 16'h0000, c, r, s;
  logic [7:0] sel_channel, a;
  dnds_pkg::dnds_rx_t rx_frame = '0;
  int fails = 0, checked = 0, cyc = 0, i;
  always #10 pclk = ~pclk;
  dnds_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .seq_active, .warmup_start, .preamble_search, .rx_busy, .rx_done, .rx_fcs_ok,
    .rx_frame, .src_check, .src_checksum, .current_network, .sel_channel, .shared_channel,
    .preamble_blind, .net_switch, .data_ind, .rx_drop, .src_hit, .src_done,
    .rx_matched_net0_flag, .rx_matched_net1_flag);
  task automatic end_sim;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      fails++;
      end_sim();
    end
  end
  function automatic logic [31:0] msk(input logic [7:0] ad);
    case (ad)
      8'h10: msk = 32'h0000000F;
      8'h14, 8'h18, 8'h1C: msk = 32'h000000FF;
      8'h34, 8'h38, 8'h3C, 8'h40: msk = 32'hFFFFFFFF;
      default: msk = 32'h0000FFFF;
    endcase
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // Slave latency is not assumed: wait on pready, with no bound of its own
  task automatic ap(input logic w, input logic [7:0] ad, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk);
    while (pready !== 1'h1);
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic rc(input logic [7:0] ad, input logic [31:0] x);
    ap(1'h0, ad, 32'h0);
    chk(q, x);
  endtask
  task automatic wt(input int k);
    int n;
    n = 0;
    do @(posedge pclk);
    while (!(k == 0 ? net_switch : k == 1 ? data_ind | rx_drop : src_done) && ++n < 5000);
  endtask
  task automatic rx(input logic ok, input logic [15:0] id, input logic [15:0] sh);
    @(posedge pclk);
    rx_frame <= '{2'h2, id, sh, 64'h0};
    rx_fcs_ok <= ok;
    rx_done <= 1'h1;
    @(posedge pclk);
    rx_done <= 1'h0;
  endtask
  task automatic sq(input logic [15:0] v);
    @(posedge pclk);
    src_check <= 1'h1;
    src_checksum <= v;
    @(posedge pclk);
    src_check <= 1'h0;
    wt(2);
    @(posedge pclk);
  endtask
  initial begin
    void'($urandom(45162));
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    rc(8'h10, 32'hC);
    rc(8'h1C, 32'h0);
    $display("test reset done");
    for (i = 0; i < 29; i++) begin
      a = i < 13 ? 8'h10 + 8'(4 * i) : 8'h80 + 8'(4 * (i - 13));
      d = $urandom();
      ap(1'h1, a, d);
      rc(a, d & msk(a));
    end
    ap(1'h1, 8'h44, 32'h5A);
    chk(32'(e), 32'h1);
    ap(1'h1, 8'h08, 32'hFFFF);
    rc(8'h08, 32'h0);
    $display("test registers done");
    ap(1'h1, 8'h14, 32'h3);
    ap(1'h1, 8'h18, 32'h7);
    ap(1'h1, 8'h00, 32'h2);
    ap(1'h1, 8'h04, 32'h3);
    repeat (200) @(posedge pclk);
    rc(8'h08, 32'h3);
    seq_active <= 1'h1;
    preamble_search <= 1'h1;
    warmup_start <= 1'h1;
    @(posedge pclk);
    warmup_start <= 1'h0;
    wt(0);
    chk(32'({current_network, sel_channel, preamble_blind}), 32'h20F);
    rc(8'h0C, 32'h21);
    ap(1'h0, 8'h08, 32'h0);
    chk(32'(q > 1), 32'h1);
    ap(1'h1, 8'h00, 32'h0);
    ap(1'h0, 8'h08, 32'h0);
    d = q;
    repeat (200) @(posedge pclk);
    rc(8'h08, d);
    chk(32'(current_network), 32'h0);
    // Blind spot must expire before the next switch, or it would retrigger
    repeat (3500) @(posedge pclk);
    ap(1'h1, 8'h00, 32'h2);
    ap(1'h1, 8'h04, 32'h5);
    repeat (120) @(posedge pclk);
    ap(1'h0, 8'h08, 32'h0);
    chk(32'(q < 5), 32'h1);
    preamble_search <= 1'h0;
    rx_busy <= 1'h1;
    repeat (400) @(posedge pclk);
    chk(32'(current_network), 32'h0);
    rx_busy <= 1'h0;
    rx(1'h0, 16'h0000, 16'h0000);
    wt(0);
    chk(32'(current_network), 32'h1);
    ap(1'h1, 8'h00, 32'h0);
    repeat (3500) @(posedge pclk);
    $display("test dwell done");
    r = 16'($urandom());
    // Top bit cleared so s and its neighbour never hit the broadcast short address
    s = 16'($urandom()) & 16'h7FFF;
    ap(1'h1, 8'h18, 32'h3);
    for (i = 0; i < 4; i++) ap(1'h1, 8'h24 + 8'(4 * i), i < 2 ? 32'(r) : 32'(s));
    chk(32'(shared_channel), 32'h1);
    rx(1'h1, r, s);
    wt(1);
    chk(32'({data_ind, rx_matched_net0_flag, rx_matched_net1_flag}), 32'h7);
    ap(1'h1, 8'h30, 32'(s ^ 16'h0001));
    rx(1'h1, r, s ^ 16'h0001);
    wt(1);
    chk(32'({data_ind, rx_matched_net0_flag, rx_matched_net1_flag}), 32'h5);
    ap(1'h1, 8'h18, 32'h7);
    rx(1'h1, r, s ^ 16'h0001);
    wt(1);
    chk(32'({data_ind, rx_drop}), 32'h1);
    $display("test filter done");
    c = 16'($urandom());
    ap(1'h1, 8'h10, 32'h8);
    ap(1'h1, 8'h9C, 32'(c));
    ap(1'h1, 8'hA0, 32'(c ^ 16'h0001));
    for (i = 0; i < 2; i++) begin
      ap(1'h1, 8'h00, 32'(i));
      sq(c);
      chk(32'(src_hit), 32'(i == 0));
      sq(c ^ 16'h0001);
      chk(32'(src_hit), 32'(i == 1));
    end
    $display("test source match done");
    end_sim();
  end
endmodule
bind dnds_top dnds_properties u_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .src_check, .current_network, .shared_channel,
  .preamble_blind, .net_switch, .data_ind, .rx_drop, .src_hit, .src_done,
  .rx_matched_net0_flag, .rx_matched_net1_flag);
`default_nettype wire
